// File: rftx_pkg.sv
package rftx_pkg;
    // register map: printed offsets are not all multiples of four, so they
    // are register indices; the byte address is four times the index
    localparam logic [15:0] CTRL_IDX       = 16'h1832;
    localparam logic [15:0] FRAME_LEN_IDX  = 16'h1831;
    localparam logic [15:0] IRQ_STATUS_IDX = 16'h1840;
    localparam logic [15:0] IRQ_MASK_IDX   = 16'h1841;
    localparam int          ADDR_W         = 16;

    // control register fields
    localparam int          START_BIT      = 7;
    localparam int          PWR_LSB        = 0;
    localparam int          PWR_W          = 5;
    localparam logic [7:0]  CTRL_RESET     = 8'h00;
    localparam logic [7:0]  FRAME_RESET    = 8'h00;
    localparam logic [4:0]  PWR_LOW_MODE   = 5'h00;
    localparam logic [4:0]  PWR_MAX_CODE   = 5'h14;

    // interrupt status bits
    localparam int          IRQ_DONE_BIT   = 0;
    localparam int          IRQ_ABORT_BIT  = 1;
    localparam int          IRQ_W          = 2;

    // default bit period in reference clock cycles
    localparam int          BIT_CYCLES_DEF = 16;
endpackage

// File: rftx_ctrl.sv
// Contract
// - Setting bit 7 of the control register starts sending the data buffer, frame_bit_count+1 bits long.
// - The start bit clears itself when the last bit of the frame has been sent.
// - The radio module reset clears the start bit and ends any frame in flight.
// - Writing zero to the start bit during a frame stops sending before the frame completes.
// - The start bit reads 1 while a frame is in flight and 0 otherwise.
// - Bits 4:0 hold a readable five-bit power select that resets to zero.
// - Power code zero picks the fixed low-power amplifier mode of about -10 dBm.
// - Codes one to 20 raise the level in 0.5 dB steps from -1.5 dBm.
// - A frame length value of zero sends no frame when the start bit is set.
`timescale 1ns/100ps
module rftx_ctrl
#(
    parameter int BIT_CYCLES = rftx_pkg::BIT_CYCLES_DEF
)
(
    // clock and reset
    input  wire logic              ref_clk_i,
    input  wire logic              rst_i,
    input  wire logic              radio_module_reset_i,
    // register port
    input  wire logic [15:0]       addr_i,
    input  wire logic [7:0]        wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [7:0]        rdata_o,
    // data buffer and modulator side
    output logic      [7:0]        buf_bit_index_o,
    output logic                   tx_active_o,
    output logic                   tx_bit_strobe_o,
    output logic      [4:0]        tx_power_select_o,
    output logic                   pa_low_power_mode_o,
    output logic                   pwr_code_reserved_o,
    // interrupt
    output logic                   irq_o
);
    initial
    begin
        if (BIT_CYCLES < 1 || BIT_CYCLES > 65535)
            $error("BIT_CYCLES out of range");
    end

    typedef enum logic [0:0] {ST_IDLE, ST_SEND} rftx_state_t;

    rftx_state_t              state_r, state_nxt;
    logic [7:0]               frame_len_r, frame_len_nxt;
    logic [4:0]               pwr_r, pwr_nxt;
    logic [7:0]               bit_idx_r, bit_idx_nxt;
    logic [15:0]              cyc_r, cyc_nxt;
    logic                     strobe_r, strobe_nxt;
    logic [1:0]               irq_st_r, irq_st_nxt;
    logic [1:0]               irq_mask_r, irq_mask_nxt;
    logic [7:0]               rdata_r, rdata_nxt;
    logic                     rmr_s1_r, rmr_s2_r;

    logic                     wr_ctrl, wr_frame, wr_stat, wr_mask;
    logic [1:0]               irq_set;

    assign wr_ctrl  = wr_i && addr_i == rftx_pkg::CTRL_IDX;
    assign wr_frame = wr_i && addr_i == rftx_pkg::FRAME_LEN_IDX;
    assign wr_stat  = wr_i && addr_i == rftx_pkg::IRQ_STATUS_IDX;
    assign wr_mask  = wr_i && addr_i == rftx_pkg::IRQ_MASK_IDX;

    // reset pin comes from another domain: two flops before use
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rmr_s1_r <= 1'b0;
            rmr_s2_r <= 1'b0;
        end
        else
        begin
            rmr_s1_r <= radio_module_reset_i;
            rmr_s2_r <= rmr_s1_r;
        end
    end

    always_comb
    begin
        state_nxt     = state_r;
        frame_len_nxt = frame_len_r;
        pwr_nxt       = pwr_r;
        bit_idx_nxt   = bit_idx_r;
        cyc_nxt       = cyc_r;
        strobe_nxt    = 1'b0;
        irq_set       = 2'b00;
        if (wr_frame)
            frame_len_nxt = wdata_i;
        if (wr_ctrl)
            pwr_nxt = wdata_i[rftx_pkg::PWR_LSB +: rftx_pkg::PWR_W];
        case (state_r)
            ST_IDLE:
            begin
                // zero length sends nothing, bit stays clear
                if (wr_ctrl && wdata_i[rftx_pkg::START_BIT]
                    && frame_len_r != 8'h00)
                begin
                    state_nxt   = ST_SEND;
                    bit_idx_nxt = 8'h00;
                    cyc_nxt     = 16'h0000;
                    strobe_nxt  = 1'b1;
                end
            end
            ST_SEND:
            begin
                if (wr_ctrl && !wdata_i[rftx_pkg::START_BIT])
                begin
                    state_nxt = ST_IDLE;
                    irq_set[rftx_pkg::IRQ_ABORT_BIT] = 1'b1;
                end
                else if (cyc_r == 16'(BIT_CYCLES - 1))
                begin
                    cyc_nxt = 16'h0000;
                    if (bit_idx_r == frame_len_r)
                    begin
                        state_nxt = ST_IDLE;
                        irq_set[rftx_pkg::IRQ_DONE_BIT] = 1'b1;
                    end
                    else
                    begin
                        bit_idx_nxt = bit_idx_r + 8'h01;
                        strobe_nxt  = 1'b1;
                    end
                end
                else
                    cyc_nxt = cyc_r + 16'h0001;
            end
            default:
                state_nxt = ST_IDLE;
        endcase
        if (rmr_s2_r)
        begin
            state_nxt     = ST_IDLE;
            frame_len_nxt = rftx_pkg::FRAME_RESET;
            pwr_nxt       = rftx_pkg::PWR_LOW_MODE;
            bit_idx_nxt   = 8'h00;
            cyc_nxt       = 16'h0000;
            strobe_nxt    = 1'b0;
        end
    end

    // set wins over write-one-to-clear
    always_comb
    begin
        irq_st_nxt = irq_st_r;
        irq_mask_nxt = irq_mask_r;
        if (wr_stat)
            irq_st_nxt = irq_st_r & ~wdata_i[1:0];
        irq_st_nxt = irq_st_nxt | irq_set;
        if (wr_mask)
            irq_mask_nxt = wdata_i[1:0];
    end

    always_comb
    begin
        rdata_nxt = 8'h00;
        if (rd_i)
        begin
            case (addr_i)
                rftx_pkg::CTRL_IDX:
                    rdata_nxt = {state_r == ST_SEND, 2'b00, pwr_r};
                rftx_pkg::FRAME_LEN_IDX:
                    rdata_nxt = frame_len_r;
                rftx_pkg::IRQ_STATUS_IDX:
                    rdata_nxt = {6'h00, irq_st_r};
                rftx_pkg::IRQ_MASK_IDX:
                    rdata_nxt = {6'h00, irq_mask_r};
                default:
                    rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_r     <= ST_IDLE;
            frame_len_r <= rftx_pkg::FRAME_RESET;
            pwr_r       <= rftx_pkg::PWR_LOW_MODE;
            bit_idx_r   <= 8'h00;
            cyc_r       <= 16'h0000;
            strobe_r    <= 1'b0;
            irq_st_r    <= 2'b00;
            irq_mask_r  <= 2'b00;
            rdata_r     <= 8'h00;
        end
        else
        begin
            state_r     <= state_nxt;
            frame_len_r <= frame_len_nxt;
            pwr_r       <= pwr_nxt;
            bit_idx_r   <= bit_idx_nxt;
            cyc_r       <= cyc_nxt;
            strobe_r    <= strobe_nxt;
            irq_st_r    <= irq_st_nxt;
            irq_mask_r  <= irq_mask_nxt;
            rdata_r     <= rdata_nxt;
        end
    end

    assign rdata_o           = rdata_r;
    assign buf_bit_index_o   = bit_idx_r;
    assign tx_active_o       = state_r == ST_SEND;
    assign tx_bit_strobe_o   = strobe_r;
    assign tx_power_select_o = pwr_r;
    // code zero is a separate fixed amplifier mode, not the bottom step
    assign pa_low_power_mode_o = pwr_r == rftx_pkg::PWR_LOW_MODE;
    // test codes are passed through but flagged; software must avoid them
    assign pwr_code_reserved_o = pwr_r > rftx_pkg::PWR_MAX_CODE;
    assign irq_o = |(irq_st_r & irq_mask_r);
endmodule

// File: rftx_ctrl_monitor.sv
`timescale 1ns/100ps
module rftx_ctrl_monitor
(
    input wire logic        ref_clk_i,
    input wire logic        rst_i,
    input wire logic        radio_module_reset_i,
    input wire logic [15:0] addr_i,
    input wire logic [7:0]  wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [7:0]  rdata_o,
    input wire logic [7:0]  buf_bit_index_o,
    input wire logic        tx_active_o,
    input wire logic        tx_bit_strobe_o,
    input wire logic [4:0]  tx_power_select_o,
    input wire logic        pa_low_power_mode_o,
    input wire logic        pwr_code_reserved_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    sequence mrst_held;
        radio_module_reset_i [*3];
    endsequence
    sequence ctrl_rd;
        rd_i && addr_i == rftx_pkg::CTRL_IDX;
    endsequence
    chk_status_read: assert property
        (ctrl_rd |=> rdata_o[7] == $past(tx_active_o)) else $error("status");
    chk_rsvd_zero: assert property
        (ctrl_rd |=> rdata_o[6:5] == 2'b00) else $error("reserved bits");
    chk_low_mode: assert property
        (pa_low_power_mode_o == (tx_power_select_o == 5'h00)) else $error("low");
    chk_test_code: assert property
        (pwr_code_reserved_o == (tx_power_select_o > 5'h14)) else $error("code");
    chk_frame_launch: assert property
        ($rose(tx_active_o) |-> tx_bit_strobe_o && buf_bit_index_o == 8'h00)
        else $error("launch");
    chk_strobe_gap: assert property
        (tx_bit_strobe_o && tx_active_o |=> !tx_bit_strobe_o) else $error("gap");
    chk_abort_stop: assert property
        (wr_i && addr_i == rftx_pkg::CTRL_IDX && !wdata_i[7] && tx_active_o
        |=> !tx_active_o) else $error("abort");
    chk_mreset_end: assert property
        (mrst_held |-> ##[0:3] !tx_active_o) else $error("module reset");
endmodule
bind rftx_ctrl rftx_ctrl_monitor u_mon (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .radio_module_reset_i(radio_module_reset_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .buf_bit_index_o(buf_bit_index_o), .tx_active_o(tx_active_o),
    .tx_bit_strobe_o(tx_bit_strobe_o), .tx_power_select_o(tx_power_select_o),
    .pa_low_power_mode_o(pa_low_power_mode_o),
    .pwr_code_reserved_o(pwr_code_reserved_o));

// File: rftx_ctrl_test.sv
`timescale 1ns/100ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin error_cnt++; \
    $display("wrong value at %0t: %h not %h", $time, a, e); end end
module rftx_ctrl_test;
    logic        ref_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        radio_module_reset_i = 1'b0;
    logic [15:0] addr_i = 16'h0000;
    logic [7:0]  wdata_i = 8'h00;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic [7:0]  rdata_o;
    logic [4:0]  tx_power_select_o;
    logic [7:0]  bit_idx;
    logic        tx_active_o, tx_bit_strobe_o, pa_low_power_mode_o;
    logic        pwr_code_reserved_o, irq_o, irq_a;
    int          error_cnt = 0;
    int          tests_run = 0;
    int          n;
    rftx_ctrl #(.BIT_CYCLES(2)) uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .radio_module_reset_i(radio_module_reset_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .buf_bit_index_o(bit_idx), .tx_active_o(tx_active_o),
        .tx_bit_strobe_o(tx_bit_strobe_o), .irq_o(irq_o),
        .tx_power_select_o(tx_power_select_o),
        .pa_low_power_mode_o(pa_low_power_mode_o),
        .pwr_code_reserved_o(pwr_code_reserved_o));
    initial forever #5 ref_clk_i = ~ref_clk_i;
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1 `CHK(rdata_o, e)
    endtask
    task automatic t_power;
        rd(rftx_pkg::CTRL_IDX, 8'h00);
        for (int c = 0; c < 32; c++)
        begin
            // reserved bits are written high and must not stick
            wr(rftx_pkg::CTRL_IDX, 8'h60 | c[7:0]);
            rd(rftx_pkg::CTRL_IDX, c[7:0]);
            `CHK(tx_power_select_o, c[4:0])
            `CHK(pa_low_power_mode_o, c == 0)
            `CHK(pwr_code_reserved_o, c > 20)
        end
    endtask
    task automatic t_frame;
        wr(rftx_pkg::FRAME_LEN_IDX, 8'h03);
        wr(rftx_pkg::CTRL_IDX, 8'h84);
        n = 0;
        repeat (30)
        begin
            #1;
            if (tx_bit_strobe_o)
            begin
                `CHK(bit_idx, n[7:0])
                n++;
            end
            @(posedge ref_clk_i);
        end
        `CHK(n, 4)
        rd(rftx_pkg::CTRL_IDX, 8'h04);
        rd(rftx_pkg::IRQ_STATUS_IDX, 8'h01);
        wr(rftx_pkg::IRQ_MASK_IDX, 8'h00);
        @(posedge ref_clk_i);
        #1 irq_a = irq_o;
        wr(rftx_pkg::IRQ_MASK_IDX, 8'h03);
        @(posedge ref_clk_i);
        `CHK(irq_a, 1'b0)
        #1 `CHK(irq_o, 1'b1)
        wr(rftx_pkg::IRQ_STATUS_IDX, 8'h01);
        rd(rftx_pkg::IRQ_STATUS_IDX, 8'h00);
        `CHK(irq_o, 1'b0)
    endtask
    task automatic t_zero;
        wr(rftx_pkg::FRAME_LEN_IDX, 8'h00);
        wr(rftx_pkg::CTRL_IDX, 8'h80);
        #1 `CHK(tx_active_o, 1'b0)
        rd(rftx_pkg::CTRL_IDX, 8'h00);
        rd(rftx_pkg::IRQ_STATUS_IDX, 8'h00);
        rd(16'h0000, 8'h00);
    endtask
    task automatic t_abort;
        wr(rftx_pkg::FRAME_LEN_IDX, 8'hC8);
        wr(rftx_pkg::CTRL_IDX, 8'h80);
        repeat (20) @(posedge ref_clk_i);
        rd(rftx_pkg::CTRL_IDX, 8'h80);
        wr(rftx_pkg::CTRL_IDX, 8'h02);
        #1 `CHK(tx_active_o, 1'b0)
        rd(rftx_pkg::IRQ_STATUS_IDX, 8'h02);
    endtask
    task automatic t_mreset;
        wr(rftx_pkg::CTRL_IDX, 8'h85);
        radio_module_reset_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        radio_module_reset_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        #1 `CHK(tx_active_o, 1'b0)
        rd(rftx_pkg::CTRL_IDX, 8'h00);
        rd(rftx_pkg::FRAME_LEN_IDX, 8'h00);
    endtask
    task automatic finish_test;
        $display("errors %0d of %0d checks", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        #50000;
        error_cnt++;
        finish_test;
    end
    initial
    begin
        repeat (4) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        t_power;
        t_frame;
        t_zero;
        t_abort;
        t_mreset;
        finish_test;
    end
endmodule
